// >>> rtl/acs_csr.v
// Purpose: Adapter control and status register: ECC syndrome capture, timeout select, lockout.
// Assumes: AHB-Lite slave, single word transfers, zero wait states, OKAY response.
// Notes: Error flags live in a write-one-to-clear summary register in this block.
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_csr #(
    parameter [31:0] LONG_TMO_CYC = `ACS_LONG_TMO_CYC,
    parameter [31:0] SHORT_TMO_CYC = `ACS_SHORT_TMO_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire ecc_err_pmr_corr,
    input wire ecc_err_pmr_unc,
    input wire ecc_err_dma_corr,
    input wire ecc_err_dma_unc,
    input wire [11:0] ecc_syndrome,
    input wire lockout_in_n,
    input wire lockout_request,
    output reg lockout_out,
    output reg lockout_out_en,
    output wire lockout_hold,
    input wire tmo_start,
    input wire tmo_done,
    output reg tmo_expired,
    output wire irq
);
    // Idle and counting states of the transaction timer.
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg ph_valid;
    reg ph_write;
    reg [7:0] ph_addr;
    reg short_tmo;
    reg lock_resp_en;
    reg lock_asrt_en;
    reg [3:0] err_flags;
    reg [`ACS_SYN_W-1:0] syndrome;
    reg syn_locked;
    reg [`ACS_IRQ_W-1:0] irq_stat;
    reg [`ACS_IRQ_W-1:0] irq_mask;
    reg [1:0] tmo_state;
    reg [31:0] tmo_cnt;
    reg lock_seen_d;
    wire lock_seen;
    wire lockout_level;
    wire [3:0] err_in;
    wire [3:0] err_clr;
    wire [3:0] next_err;
    wire any_err_in;
    wire wr_csr;
    wire wr_esr;
    wire wr_istat;
    wire wr_imask;
    wire [31:0] tmo_limit;
    wire tmo_hit;
    reg [`ACS_IRQ_W-1:0] irq_evt;
    reg [31:0] next_rdata;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase is latched; the write data follows one cycle later.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end else if (hready) begin
            ph_valid <= hsel & htrans[1];
            ph_write <= hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    assign wr_csr = ph_valid & ph_write & (ph_addr == `ACS_OFF_CSR);
    assign wr_esr = ph_valid & ph_write & (ph_addr == `ACS_OFF_ESR);
    assign wr_istat = ph_valid & ph_write & (ph_addr == `ACS_OFF_IRQ_STAT);
    assign wr_imask = ph_valid & ph_write & (ph_addr == `ACS_OFF_IRQ_MASK);

    // Only the three documented control bits are writable.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            short_tmo <= 1'b0;
            lock_resp_en <= 1'b1;
            lock_asrt_en <= 1'b1;
        end else if (wr_csr) begin
            short_tmo <= hwdata[`ACS_BIT_SHORT_TMO];
            lock_resp_en <= hwdata[`ACS_BIT_LOCK_RESP];
            lock_asrt_en <= hwdata[`ACS_BIT_LOCK_ASRT];
        end
    end

    assign err_in = {ecc_err_pmr_corr, ecc_err_pmr_unc, ecc_err_dma_corr, ecc_err_dma_unc};
    assign any_err_in = |err_in;
    assign err_clr = wr_esr ? {hwdata[`ACS_ESR_PMR_CORR], hwdata[`ACS_ESR_PMR_UNC],
                               hwdata[`ACS_ESR_DMA_CORR], hwdata[`ACS_ESR_DMA_UNC]} : 4'h0;
    // A new error in the same cycle as its clear keeps the flag set.
    assign next_err = (err_flags & ~err_clr) | err_in;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_flags <= 4'h0;
        end else begin
            err_flags <= next_err;
        end
    end

    // The lock is held in its own register that follows the flags, so the syndrome stays valid exactly while
    // any flag is set and is free again the cycle after the last flag is cleared.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            syndrome <= {`ACS_SYN_W{1'b0}};
            syn_locked <= 1'b0;
        end else begin
            if (any_err_in && !syn_locked) begin
                syndrome <= ecc_syndrome;
                syn_locked <= 1'b1;
            end else if (syn_locked && (next_err == 4'h0)) begin
                syn_locked <= 1'b0;
            end
            // no load path while syn_locked is set.
        end
    end

    acs_sync3 u_lock_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .din(~lockout_in_n),
        .dout(lockout_level)
    );

    assign lock_seen = lockout_level & lock_resp_en;
    assign lockout_hold = lock_seen;

    // Lockout line is open-drain and active low: drive a zero only when allowed.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lockout_out <= 1'b0;
            lockout_out_en <= 1'b0;
            lock_seen_d <= 1'b0;
        end else begin
            lockout_out <= 1'b0;
            lockout_out_en <= lockout_request & lock_asrt_en;
            lock_seen_d <= lock_seen;
        end
    end

    // The count uses the top of the selected range; the limit is fixed per range.
    assign tmo_limit = short_tmo ? SHORT_TMO_CYC : LONG_TMO_CYC;
    assign tmo_hit = (tmo_cnt >= tmo_limit - 32'h00000001);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_state <= ST_IDLE;
            tmo_cnt <= 32'h00000000;
            tmo_expired <= 1'b0;
        end else begin
            tmo_expired <= 1'b0;
            case (tmo_state)
                ST_IDLE: begin
                    tmo_cnt <= 32'h00000000;
                    if (tmo_start) begin
                        tmo_state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tmo_done) begin
                        tmo_state <= ST_IDLE;
                    end else if (tmo_hit) begin
                        tmo_expired <= 1'b1;
                        tmo_state <= ST_IDLE;
                    end else begin
                        tmo_cnt <= tmo_cnt + 32'h00000001;
                    end
                end
                default: begin
                    tmo_state <= ST_IDLE;
                end
            endcase
        end
    end

    always @* begin
        irq_evt = {`ACS_IRQ_W{1'b0}};
        irq_evt[`ACS_IRQ_ERR] = any_err_in;
        irq_evt[`ACS_IRQ_TMO] = (tmo_state == ST_RUN) & ~tmo_done & tmo_hit;
        irq_evt[`ACS_IRQ_LOCK_SEEN] = lock_seen & ~lock_seen_d;
        irq_evt[`ACS_IRQ_SYN_CAP] = any_err_in & ~syn_locked;
    end

    // Status bits are write-one-to-clear; a same-cycle event wins over the clear.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= {`ACS_IRQ_W{1'b0}};
            irq_mask <= {`ACS_IRQ_W{1'b0}};
        end else begin
            if (wr_istat) begin
                irq_stat <= (irq_stat & ~hwdata[`ACS_IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat <= irq_stat | irq_evt;
            end
            if (wr_imask) begin
                irq_mask <= hwdata[`ACS_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data is registered at the address phase, so a read completes with zero waits.
    always @* begin
        next_rdata = 32'h00000000;
        if (haddr[7:0] == `ACS_OFF_CSR) begin
            next_rdata[`ACS_SYN_MSB:`ACS_SYN_LSB] = syndrome;
            next_rdata[`ACS_BIT_SHORT_TMO] = short_tmo;
            next_rdata[`ACS_BIT_LOCK_RESP] = lock_resp_en;
            next_rdata[`ACS_BIT_LOCK_ASRT] = lock_asrt_en;
            // bits 16..10 and 6 stay zero.
        end else if (haddr[7:0] == `ACS_OFF_ESR) begin
            next_rdata[`ACS_ESR_PMR_CORR] = err_flags[3];
            next_rdata[`ACS_ESR_PMR_UNC] = err_flags[2];
            next_rdata[`ACS_ESR_DMA_CORR] = err_flags[1];
            next_rdata[`ACS_ESR_DMA_UNC] = err_flags[0];
        end else if (haddr[7:0] == `ACS_OFF_IRQ_STAT) begin
            next_rdata[`ACS_IRQ_W-1:0] = irq_stat;
        end else if (haddr[7:0] == `ACS_OFF_IRQ_MASK) begin
            next_rdata[`ACS_IRQ_W-1:0] = irq_mask;
        end else if (haddr[7:0] == `ACS_OFF_TMO_LIMIT) begin
            next_rdata = tmo_limit;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end
endmodule

// >>> rtl/acs_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts for the adapter CSR.
// Assumes: 32-bit AHB-Lite register bus clocked at 250 MHz.
// Notes: Offsets are byte addresses of aligned words.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_CSR 8'h00
`define ACS_OFF_ESR 8'h04
`define ACS_OFF_IRQ_STAT 8'h08
`define ACS_OFF_IRQ_MASK 8'h0C
`define ACS_OFF_TMO_LIMIT 8'h10
`define ACS_SYN_LSB 17
`define ACS_SYN_MSB 28
`define ACS_SYN_W 12
`define ACS_BIT_SHORT_TMO 9
`define ACS_BIT_LOCK_RESP 8
`define ACS_BIT_LOCK_ASRT 7
`define ACS_ESR_PMR_CORR 13
`define ACS_ESR_PMR_UNC 12
`define ACS_ESR_DMA_CORR 10
`define ACS_ESR_DMA_UNC 9
`define ACS_CSR_WMASK 32'h00000380
`define ACS_CSR_RESET 32'h00000180
`define ACS_ESR_MASK 32'h00003600
`define ACS_IRQ_W 4
`define ACS_IRQ_ERR 0
`define ACS_IRQ_TMO 1
`define ACS_IRQ_LOCK_SEEN 2
`define ACS_IRQ_SYN_CAP 3
`define ACS_CLK_MHZ 250
`define ACS_SHORT_TMO_US 960
`define ACS_LONG_TMO_MS 15
`define ACS_SHORT_TMO_CYC (`ACS_SHORT_TMO_US * `ACS_CLK_MHZ)
`define ACS_LONG_TMO_CYC (`ACS_LONG_TMO_MS * 1000 * `ACS_CLK_MHZ)
`endif

// >>> rtl/acs_sync3.v
// Purpose: Three-flop synchroniser for a pin level with agreement check.
// Assumes: Input is asynchronous to clk.
// Notes: Output changes only when the second and third stages agree.
`timescale 1ns/1ps
module acs_sync3 (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

// >>> tb/acs_csr_props.sv
// Purpose: Port-level assertions for the adapter control and status block.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: The timer window is loose because the exact count offset is the designer's choice.
`timescale 1ns/1ps
module acs_csr_props #(
    parameter [31:0] LONG_TMO_CYC = 100,
    parameter [31:0] SHORT_TMO_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic lockout_in_n,
    input wire logic lockout_request,
    input wire logic lockout_out,
    input wire logic lockout_out_en,
    input wire logic lockout_hold,
    input wire logic tmo_start,
    input wire logic tmo_expired
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_csr;
    logic [31:0] cyc;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_csr <= 1'b0;
            cyc <= 32'h00000000;
        end else begin
            rd_csr <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
            cyc <= tmo_start ? 32'h00000000 : cyc + 32'h00000001;
        end
    end
    property p_out_low; lockout_out == 1'b0; endproperty
    a_out_low: assert property (p_out_low) else $error("lockout value not low");
    property p_en_cause; $rose(lockout_out_en) |-> $past(lockout_request); endproperty
    a_en_cause: assert property (p_en_cause) else $error("drive without request");
    property p_en_drop; !lockout_request |=> !lockout_out_en; endproperty
    a_en_drop: assert property (p_en_drop) else $error("drive kept after request");
    property p_hold_cause; $rose(lockout_hold) |-> !$past(lockout_in_n, 2); endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("hold without line");
    // The agreement stage can keep the old level for one edge, so five idle samples are needed.
    property p_hold_idle; lockout_in_n [*5] |-> !lockout_hold; endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("hold with idle line");
    property p_tmo_pulse; tmo_expired |=> !tmo_expired; endproperty
    a_tmo_pulse: assert property (p_tmo_pulse) else $error("expiry not one cycle");
    property p_tmo_span;
        tmo_expired |-> cyc + 1 >= SHORT_TMO_CYC && cyc <= LONG_TMO_CYC + 2;
    endproperty
    a_tmo_span: assert property (p_tmo_span) else $error("expiry outside ranges");
    property p_rsvd; rd_csr |-> hrdata[16:10] == 7'h00 && !hrdata[6]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule
bind acs_csr acs_csr_props #(.LONG_TMO_CYC(LONG_TMO_CYC), .SHORT_TMO_CYC(SHORT_TMO_CYC)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .lockout_in_n(lockout_in_n),
    .lockout_request(lockout_request), .lockout_out(lockout_out),
    .lockout_out_en(lockout_out_en), .lockout_hold(lockout_hold),
    .tmo_start(tmo_start), .tmo_expired(tmo_expired));

// >>> tb/acs_far_node.sv
// Purpose: Other bus nodes sharing the open-drain lockout line.
// Assumes: The line has a pull-up, so it idles high when nobody pulls.
// Notes: Wire level is resolved from every puller's enable.
`timescale 1ns/1ps
module acs_far_node (
    input wire logic pull,
    input wire logic dut_en,
    output wire logic line_n
);
    assign line_n = !(pull || dut_en);
endmodule

// >>> tb/adapter_csr_syndrome_lockout_test.sv
// Purpose: Register-level test of syndrome capture, timeout select and lockout enables.
// Assumes: Zero-wait AHB-Lite slave; short and long timer counts shrunk by parameter.
// Notes: Flags are sampled at the falling edge so edge updates have landed.
`timescale 1ns/1ps
`include "acs_map.vh"
module adapter_csr_syndrome_lockout_test;
    localparam int SH = 20;
    localparam int LG = 100;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req = 0, pull = 0, st = 0, dn = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [3:0] ev = 4'h0;
    logic [11:0] syn = 12'h000;
    wire hready, hresp, en, line_n, hold, lo, exp_t, irq;
    wire [31:0] hrdata;
    int err_total = 0, compares = 0, n;
    acs_csr #(.LONG_TMO_CYC(LG), .SHORT_TMO_CYC(SH)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .ecc_err_pmr_corr(ev[3]), .ecc_err_pmr_unc(ev[2]), .ecc_err_dma_corr(ev[1]),
        .ecc_err_dma_unc(ev[0]), .ecc_syndrome(syn), .lockout_in_n(line_n),
        .lockout_request(req), .lockout_out(lo), .lockout_out_en(en), .lockout_hold(hold),
        .tmo_start(st), .tmo_done(dn), .tmo_expired(exp_t), .irq(irq));
    acs_far_node i_far (.pull(pull), .dut_en(en), .line_n(line_n));
    initial forever #2 hclk = ~hclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic ecc(input logic [3:0] e, input logic [11:0] s);
        ev <= e;
        syn <= s;
        @(posedge hclk);
        ev <= 4'h0;
        @(posedge hclk);
    endtask
    task automatic tmo(input logic abort);
        st <= 1;
        @(posedge hclk);
        st <= 0;
        for (n = 0; n < 150; n++) begin
            @(posedge hclk);
            dn <= abort && n == 5;
            // The pulse is read at the falling edge, where its launch has settled.
            @(negedge hclk);
            if (exp_t === 1'b1) break;
        end
        @(posedge hclk);
        dn <= 0;
    endtask
    function automatic logic [31:0] csr(input logic [11:0] s, input logic [31:0] c);
        return {3'h0, s, c[16:0]};
    endfunction
    task print_verdict;
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        bus(0, `ACS_OFF_CSR, 0); chk("csr_reset", 32'h00000180, rd);
        bus(1, `ACS_OFF_CSR, 32'hFFFFFFFF);
        bus(0, `ACS_OFF_CSR, 0); chk("csr_rsvd", 32'h00000380, rd);
        bus(1, `ACS_OFF_CSR, 32'h00000180);
        bus(1, `ACS_OFF_IRQ_MASK, 32'h0000000F);
        ecc(4'h8, 12'hA5C);
        bus(0, `ACS_OFF_CSR, 0); chk("syn_cap", csr(12'hA5C, 32'h180), rd);
        chk("irq_on", 1, irq);
        bus(0, `ACS_OFF_IRQ_STAT, 0); chk("irq_stat", 32'h00000009, rd);
        chk("hresp", 0, hresp);
        ecc(4'h1, 12'h123);
        bus(0, `ACS_OFF_CSR, 0); chk("syn_lock", csr(12'hA5C, 32'h180), rd);
        bus(0, `ACS_OFF_ESR, 0); chk("esr", 32'h00002200, rd);
        bus(1, `ACS_OFF_ESR, 32'h00002000);
        ecc(4'h2, 12'h0F0);
        bus(0, `ACS_OFF_CSR, 0); chk("syn_part", csr(12'hA5C, 32'h180), rd);
        bus(1, `ACS_OFF_ESR, 32'h00003600);
        ecc(4'h4, 12'h0F0);
        bus(0, `ACS_OFF_CSR, 0); chk("syn_new", csr(12'h0F0, 32'h180), rd);
        bus(1, `ACS_OFF_IRQ_MASK, 0);
        @(negedge hclk); chk("irq_mask", 0, irq);
        @(posedge hclk);
        bus(1, `ACS_OFF_IRQ_MASK, 32'h0000000F);
        bus(1, `ACS_OFF_IRQ_STAT, 32'h0000000F);
        @(negedge hclk); chk("irq_clr", 0, irq);
        @(posedge hclk);
        bus(1, 32'h40, 32'hFFFFFFFF);
        bus(0, 32'h40, 0); chk("unmapped", 0, rd);
        bus(1, `ACS_OFF_CSR, 0);
        req <= 1;
        pull <= 1;
        repeat (6) @(posedge hclk);
        @(negedge hclk); chk("drv_off", 0, en);
        chk("hold_off", 0, hold);
        @(posedge hclk);
        bus(1, `ACS_OFF_CSR, 32'h00000180);
        repeat (6) @(posedge hclk);
        @(negedge hclk); chk("drv_on", 1, en);
        chk("hold_on", 1, hold);
        @(posedge hclk);
        req <= 0;
        pull <= 0;
        bus(1, `ACS_OFF_CSR, 32'h00000380);
        tmo(0); chk("tmo_short", 1, n >= SH - 2 && n <= SH + 2);
        bus(1, `ACS_OFF_CSR, 32'h00000180);
        tmo(0); chk("tmo_long", 1, n >= LG - 2 && n <= LG + 2);
        bus(0, `ACS_OFF_TMO_LIMIT, 0); chk("tmo_limit", LG, rd);
        tmo(1); chk("tmo_abort", 150, n);
        print_verdict;
    end
endmodule
